// [flash_cmd_defines.svh]
// command codes, status layout and sizes shared by both ends of the flash command link
// assumes inclusion by bare name from the decoder, host, checker and bench files
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_READ_ID 8'h90
`define CMD_READ_QUERY 8'h98
`define CMD_CLEAR_STATUS 8'h50
`define CMD_WORD_PROG 8'h40
`define CMD_WORD_PROG_ALT 8'h10
`define CMD_BUF_PROG 8'hE8
`define CMD_CONFIRM 8'hD0
`define CMD_FACTORY_SETUP 8'h80
`define CMD_SUSPEND 8'hB0
`define STATUS_RESET 8'h80
`define STATUS_READY_BIT 7
`define STATUS_ERR_MASK 8'h3A
`define STATUS_SEQ_ERR 8'h30
`define BUF_MAX_WORDS 32
`define BUF_CNT_W 5
`define PROG_CYCLES 16'h0010
`endif

// [flash_cmd_pkg.sv]
// types used by the device end (decoder) of the flash command link
// assumes flash_cmd_defines.svh holds the numeric constants
`default_nettype none
package flash_cmd_pkg;
    typedef enum logic [1:0] {
        RD_ARRAY = 2'b00,
        RD_STATUS = 2'b01,
        RD_ID = 2'b10,
        RD_QUERY = 2'b11
    } read_state_t;
endpackage : flash_cmd_pkg
`default_nettype wire

// [flash_bus_if.sv]
// host-to-flash parallel bus: strobes, address and split data lines
// assumes one clock for both ends; the interface resolves the data wire from dq_dev_oe
`timescale 1ns/10ps
`default_nettype none
interface flash_bus_if #(parameter int AW = 16);
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic address_valid_n;
    logic [AW-1:0] addr;
    logic [15:0] dq_host;
    logic [15:0] dq_dev;
    logic dq_dev_oe;
    logic [15:0] dq;
    assign dq = dq_dev_oe ? dq_dev : dq_host;
    modport device (input ce_n, oe_n, we_n, address_valid_n, addr, dq_host,
        output dq_dev, dq_dev_oe);
    modport host (output ce_n, oe_n, we_n, address_valid_n, addr, dq_host,
        input dq);
endinterface : flash_bus_if
`default_nettype wire

// [flash_command_decoder.sv]
// device end: command user interface, read-state select and status register
// assumes bus strobes synchronous to I_CLK_SYS; array/id/query data come from user ports
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_defines.svh"
// Contract
// - 0xFF selects array reads on sixteen lines
// - 0x70 selects status reads on low byte
// - accepted program switches reads to status
// - 0x90 selects identifier reads, sixteen lines
// - 0x98 selects query reads, low byte
// - error flags set by sequencer, cleared 0x50
// - word program latches next cycle address, data
// - during program only status and suspend (suspend is not decoded; only 0x70 is acted on)
// - async status refresh on ce or oe toggle
// - sync status refresh on ce or adv toggle
// - host writes 0xFF before array reads
// - 0x10 behaves exactly like 0x40
// - 0xE8 loads up to 32 words
// - 0xD0 confirm programs buffer into array
// - 0x80 waits for 0xD0 confirm next
// - factory mode ignores all commands
// - factory confirm latches address and data
// - reset gives array reads, status 0x80
// - host sends count minus one first
// - host uses target address first cycle
module flash_command_decoder #(
    parameter int AW = 16,
    parameter logic [15:0] FACTORY_CYCLES = 16'h0040
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    flash_bus_if.device BUS,
    input wire logic I_SYNC_MODE,
    input wire logic [15:0] I_ARRAY_DATA,
    input wire logic [15:0] I_ID_DATA,
    input wire logic [7:0] I_QUERY_DATA,
    input wire logic I_FACTORY_DONE,
    output logic O_PROG_START,
    output logic O_BUF_PROG_START,
    output logic O_FACTORY_START,
    output logic [AW-1:0] O_PROG_ADDR,
    output logic [15:0] O_PROG_DATA,
    output logic [`BUF_CNT_W:0] O_BUF_WORDS,
    output logic O_BUSY,
    output logic O_FACTORY_MODE,
    output logic [1:0] O_READ_STATE,
    output logic [7:0] O_STATUS
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WORD_SETUP = 3'b001,
        ST_BUF_COUNT = 3'b010,
        ST_BUF_DATA = 3'b011,
        ST_BUF_CONFIRM = 3'b100,
        ST_FACTORY_SETUP = 3'b101,
        ST_FACTORY = 3'b110
    } cmd_state_t;

    cmd_state_t state_q, state_d;
    flash_cmd_pkg::read_state_t rd_q, rd_d;
    logic we_n_q, ce_n_q, oe_n_q, adv_n_q;
    logic [7:0] status_q, status_d, status_snap_q;
    logic [15:0] busy_cnt_q;
    logic [`BUF_CNT_W:0] words_left_q;
    logic [15:0] buf_mem_q [0:`BUF_MAX_WORDS-1];
    logic [AW-1:0] addr_q;
    logic [15:0] data_q;

    // write completes on the rising edge of we_n while ce_n low
    wire wr_end = BUS.we_n & ~we_n_q & ~BUS.ce_n;
    wire [7:0] cmd = BUS.dq_host[7:0];
    wire busy = busy_cnt_q != 16'h0000;
    wire is_word_setup = (cmd == `CMD_WORD_PROG) | (cmd == `CMD_WORD_PROG_ALT);
    // refresh edges differ by read mode; stale snapshot keeps a read stable
    wire refresh_sync = (BUS.ce_n & ~ce_n_q) | (BUS.address_valid_n & ~adv_n_q);
    wire refresh_async = (BUS.ce_n & ~ce_n_q) | (BUS.oe_n & ~oe_n_q);
    wire refresh = I_SYNC_MODE ? refresh_sync : refresh_async;
    wire go_word = wr_end & (state_q == ST_WORD_SETUP);
    wire go_buf = wr_end & (state_q == ST_BUF_CONFIRM) & (cmd == `CMD_CONFIRM);
    wire go_fact = wr_end & (state_q == ST_FACTORY_SETUP) & (cmd == `CMD_CONFIRM);
    wire seq_err = wr_end & (((state_q == ST_BUF_CONFIRM) | (state_q == ST_FACTORY_SETUP))
                             & (cmd != `CMD_CONFIRM));
    wire buf_load = wr_end & (state_q == ST_BUF_DATA);

    always_comb begin
        state_d = state_q;
        rd_d = rd_q;
        status_d = status_q;
        if (seq_err) begin
            status_d = status_q | `STATUS_SEQ_ERR;
        end
        status_d[`STATUS_READY_BIT] = ~busy & (state_q != ST_FACTORY);
        if (state_q == ST_FACTORY) begin
            if (I_FACTORY_DONE) begin
                state_d = ST_IDLE;
            end
        end else if (wr_end && busy) begin
            if (cmd == `CMD_READ_STATUS) begin
                rd_d = flash_cmd_pkg::RD_STATUS;
            end
        end else if (wr_end) begin
            case (state_q)
                ST_IDLE: begin
                    case (cmd)
                        `CMD_READ_ARRAY: rd_d = flash_cmd_pkg::RD_ARRAY;
                        `CMD_READ_STATUS: rd_d = flash_cmd_pkg::RD_STATUS;
                        `CMD_READ_ID: rd_d = flash_cmd_pkg::RD_ID;
                        `CMD_READ_QUERY: rd_d = flash_cmd_pkg::RD_QUERY;
                        `CMD_CLEAR_STATUS: status_d = status_q & ~`STATUS_ERR_MASK;
                        `CMD_BUF_PROG: begin
                            state_d = ST_BUF_COUNT;
                            rd_d = flash_cmd_pkg::RD_STATUS;
                        end
                        `CMD_FACTORY_SETUP: begin
                            state_d = ST_FACTORY_SETUP;
                            rd_d = flash_cmd_pkg::RD_STATUS;
                        end
                        default: begin
                            if (is_word_setup) begin
                                state_d = ST_WORD_SETUP;
                                rd_d = flash_cmd_pkg::RD_STATUS;
                            end
                        end
                    endcase
                end
                ST_WORD_SETUP: state_d = ST_IDLE;
                ST_BUF_COUNT: state_d = ST_BUF_DATA;
                ST_BUF_DATA: begin
                    if (words_left_q == 6'(1)) begin
                        state_d = ST_BUF_CONFIRM;
                    end
                end
                ST_BUF_CONFIRM: state_d = ST_IDLE;
                ST_FACTORY_SETUP: state_d = (cmd == `CMD_CONFIRM) ? ST_FACTORY : ST_IDLE;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            state_q <= ST_IDLE;
            rd_q <= flash_cmd_pkg::RD_ARRAY;
            status_q <= `STATUS_RESET;
            status_snap_q <= `STATUS_RESET;
            we_n_q <= 1'b1;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            adv_n_q <= 1'b1;
            busy_cnt_q <= 16'h0000;
            words_left_q <= '0;
            addr_q <= '0;
            data_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            rd_q <= rd_d;
            status_q <= status_d;
            we_n_q <= BUS.we_n;
            ce_n_q <= BUS.ce_n;
            oe_n_q <= BUS.oe_n;
            adv_n_q <= BUS.address_valid_n;
            if (refresh) begin
                status_snap_q <= status_d;
            end
            if (go_word | go_fact) begin
                addr_q <= BUS.addr;
                data_q <= BUS.dq_host;
            end
            if (go_word | go_buf) begin
                busy_cnt_q <= `PROG_CYCLES;
            end else if (go_fact) begin
                busy_cnt_q <= FACTORY_CYCLES;
            end else if (busy) begin
                busy_cnt_q <= busy_cnt_q - 16'h0001;
            end
            if (wr_end && state_q == ST_BUF_COUNT) begin
                // count above the buffer size is clamped to 32 words
                words_left_q <= (BUS.dq_host[15:0] >= 16'(`BUF_MAX_WORDS)) ? 6'(`BUF_MAX_WORDS)
                              : 6'(BUS.dq_host[`BUF_CNT_W-1:0]) + 6'(1);
            end else if (buf_load) begin
                words_left_q <= words_left_q - 6'(1);
            end
        end
    end

    logic [`BUF_CNT_W:0] buf_total_q;
    logic [`BUF_CNT_W-1:0] wr_idx;
    assign wr_idx = `BUF_CNT_W'(buf_total_q - words_left_q);
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            buf_total_q <= '0;
        end else if (wr_end && state_q == ST_BUF_COUNT) begin
            buf_total_q <= (BUS.dq_host >= 16'(`BUF_MAX_WORDS)) ? 6'(`BUF_MAX_WORDS)
                         : 6'(BUS.dq_host[`BUF_CNT_W-1:0]) + 6'(1);
        end
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (buf_load) begin
            buf_mem_q[wr_idx] <= BUS.dq_host;
        end
    end

    logic [15:0] rd_data;
    always_comb begin
        case (rd_q)
            flash_cmd_pkg::RD_ARRAY: rd_data = I_ARRAY_DATA;
            flash_cmd_pkg::RD_STATUS: rd_data = {8'h00, status_snap_q};
            flash_cmd_pkg::RD_ID: rd_data = I_ID_DATA;
            flash_cmd_pkg::RD_QUERY: rd_data = {8'h00, I_QUERY_DATA};
            default: rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            BUS.dq_dev <= 16'h0000;
            BUS.dq_dev_oe <= 1'b0;
            O_PROG_START <= 1'b0;
            O_BUF_PROG_START <= 1'b0;
            O_FACTORY_START <= 1'b0;
            O_PROG_ADDR <= '0;
            O_PROG_DATA <= 16'h0000;
            O_BUF_WORDS <= '0;
            O_BUSY <= 1'b0;
            O_FACTORY_MODE <= 1'b0;
            O_READ_STATE <= 2'b00;
            O_STATUS <= `STATUS_RESET;
        end else begin
            BUS.dq_dev <= rd_data;
            BUS.dq_dev_oe <= ~BUS.ce_n & ~BUS.oe_n & BUS.we_n;
            O_PROG_START <= go_word;
            O_BUF_PROG_START <= go_buf;
            O_FACTORY_START <= go_fact;
            O_PROG_ADDR <= (go_word | go_fact) ? BUS.addr : addr_q;
            O_PROG_DATA <= go_buf ? buf_mem_q[0] : ((go_word | go_fact) ? BUS.dq_host : data_q);
            O_BUF_WORDS <= buf_total_q;
            O_BUSY <= busy | (state_q == ST_FACTORY);
            O_FACTORY_MODE <= state_q == ST_FACTORY;
            O_READ_STATE <= rd_q;
            O_STATUS <= status_q;
        end
    end
endmodule : flash_command_decoder
`default_nettype wire

// [flash_cmd_host.sv]
// host end: issues one command write or read per request on the flash bus
// assumes the device end samples strobes on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_defines.svh"
module flash_cmd_host #(
    parameter int AW = 16
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    flash_bus_if.host BUS,
    input wire logic I_REQ,
    input wire logic I_REQ_WRITE,
    input wire logic [AW-1:0] I_REQ_ADDR,
    input wire logic [15:0] I_REQ_DATA,
    output logic O_REQ_READY,
    output logic O_RD_VALID,
    output logic [15:0] O_RD_DATA
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_STROBE = 2'b01,
        H_SAMPLE = 2'b10,
        H_RELEASE = 2'b11
    } host_state_t;
    host_state_t st_q;
    logic wr_q;
    // every access releases ce_n, so status refreshes per read
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            st_q <= H_IDLE;
            wr_q <= 1'b0;
            BUS.ce_n <= 1'b1;
            BUS.oe_n <= 1'b1;
            BUS.we_n <= 1'b1;
            BUS.address_valid_n <= 1'b1;
            BUS.addr <= '0;
            BUS.dq_host <= 16'h0000;
            O_REQ_READY <= 1'b1;
            O_RD_VALID <= 1'b0;
            O_RD_DATA <= 16'h0000;
        end else begin
            O_RD_VALID <= 1'b0;
            case (st_q)
                H_IDLE: begin
                    if (I_REQ) begin
                        // requester supplies command order and target address; host passes them through
                        wr_q <= I_REQ_WRITE;
                        BUS.addr <= I_REQ_ADDR;
                        BUS.dq_host <= I_REQ_DATA;
                        BUS.ce_n <= 1'b0;
                        BUS.address_valid_n <= 1'b0;
                        BUS.we_n <= ~I_REQ_WRITE;
                        BUS.oe_n <= I_REQ_WRITE;
                        O_REQ_READY <= 1'b0;
                        st_q <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    BUS.address_valid_n <= 1'b1;
                    st_q <= H_SAMPLE;
                end
                H_SAMPLE: begin
                    if (!wr_q) begin
                        O_RD_DATA <= BUS.dq;
                        O_RD_VALID <= 1'b1;
                    end
                    BUS.we_n <= 1'b1;
                    BUS.oe_n <= 1'b1;
                    st_q <= H_RELEASE;
                end
                H_RELEASE: begin
                    BUS.ce_n <= 1'b1;
                    O_REQ_READY <= 1'b1;
                    st_q <= H_IDLE;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule : flash_cmd_host
`default_nettype wire

// [flash_cmd_properties.sv]
// assertions on the flash command link: bus strobes and decoder outputs
// assumes one clock, synchronous active-low reset, instantiated beside the bus
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_defines.svh"
module flash_cmd_properties #(
    parameter int AW = 16
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] dq_host,
    input wire logic O_PROG_START,
    input wire logic O_BUF_PROG_START,
    input wire logic O_FACTORY_START,
    input wire logic [AW-1:0] O_PROG_ADDR,
    input wire logic [15:0] O_PROG_DATA,
    input wire logic O_BUSY,
    input wire logic O_FACTORY_MODE,
    input wire logic [1:0] O_READ_STATE,
    input wire logic [7:0] O_STATUS
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);
    logic we_q;
    logic wsetup_q;
    logic fsetup_q;
    logic [AW-1:0] lat_a_q;
    logic [15:0] lat_d_q;
    logic [1:0] clr_q;
    wire wend = we_n && !we_q && !ce_n;
    wire [7:0] cmd = dq_host[7:0];
    // only a write outside busy, factory mode and a pending word or factory setup counts as a fresh command
    wire idle_wr = wend && !O_BUSY && !O_FACTORY_MODE && !wsetup_q && !fsetup_q;
    wire [7:0] last = lat_d_q[7:0];
    wire [1:0] rs_exp = (last == `CMD_READ_STATUS) ? 2'b01 : (last == `CMD_READ_ID) ? 2'b10
        : (last == `CMD_READ_QUERY) ? 2'b11 : 2'b00;
    wire rd_cmd = cmd inside {`CMD_READ_ARRAY, `CMD_READ_STATUS, `CMD_READ_ID, `CMD_READ_QUERY};
    wire is_word = cmd == `CMD_WORD_PROG || cmd == `CMD_WORD_PROG_ALT;
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            we_q <= 1'b1;
            wsetup_q <= 1'b0;
            fsetup_q <= 1'b0;
            clr_q <= 2'd0;
        end else begin
            we_q <= we_n;
            clr_q <= (idle_wr && cmd == `CMD_CLEAR_STATUS) ? 2'd3 : clr_q - {1'b0, clr_q != 2'd0};
            if (wend) begin
                lat_a_q <= addr;
                lat_d_q <= dq_host;
                wsetup_q <= idle_wr && is_word;
                fsetup_q <= idle_wr && cmd == `CMD_FACTORY_SETUP;
            end
        end
    end
    a_read_select: assert property (
        idle_wr && rd_cmd |-> ##[1:3] O_READ_STATE == rs_exp)
        else $error("read state does not follow read command");
    a_prog_to_status: assert property (
        (O_PROG_START || O_BUF_PROG_START) |-> ##[0:2] O_READ_STATE == 2'b01)
        else $error("program start left read state unchanged");
    a_busy_refuse: assert property (
        wend && O_BUSY && !O_FACTORY_MODE && cmd != `CMD_READ_STATUS
        |=> ($stable(O_READ_STATE) && !O_PROG_START && !O_BUF_PROG_START) [*3])
        else $error("command acted on while busy");
    a_factory_ignore: assert property (
        wend && O_FACTORY_MODE |=> (O_FACTORY_MODE && $stable(O_READ_STATE)) [*3])
        else $error("command acted on in factory mode");
    a_word_latch: assert property (
        wend && wsetup_q
        |-> ##[1:2] (O_PROG_START && O_PROG_ADDR == lat_a_q && O_PROG_DATA == lat_d_q))
        else $error("word program address or data not latched");
    a_factory_confirm: assert property (
        wend && fsetup_q && cmd == `CMD_CONFIRM
        |-> ##[1:2] (O_FACTORY_START && O_PROG_ADDR == lat_a_q && O_PROG_DATA == lat_d_q)
        ##[0:2] O_FACTORY_MODE)
        else $error("factory confirm not taken");
    a_seq_error: assert property (
        wend && fsetup_q && cmd != `CMD_CONFIRM
        |-> ##[1:3] (O_STATUS & `STATUS_SEQ_ERR) == `STATUS_SEQ_ERR)
        else $error("wrong confirm did not flag sequence error");
    a_status_clear: assert property (
        idle_wr && cmd == `CMD_CLEAR_STATUS |-> ##[1:3] (O_STATUS & `STATUS_ERR_MASK) == 8'h00)
        else $error("clear status left error bits");
    a_err_sticky: assert property (
        |($past(O_STATUS) & ~O_STATUS & `STATUS_ERR_MASK) |-> clr_q != 2'd0)
        else $error("error bit fell without clear command");
    a_reset_state: assert property (
        $rose(I_RST_N) |-> O_READ_STATE == 2'b00 && O_STATUS == `STATUS_RESET)
        else $error("wrong state after reset");
endmodule : flash_cmd_properties
`default_nettype wire

// [tb.sv]
// self-checking bench: host end and decoder joined through the bus interface
// assumes the design files and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_defines.svh"
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic req_wr = 1'b0;
    logic [15:0] req_a = 16'h0000;
    logic [15:0] req_d = 16'h0000;
    logic sync = 1'b0;
    logic [15:0] arr_d = 16'h0000;
    logic [15:0] id_d = 16'h0000;
    logic [7:0] qry_d = 8'h00;
    logic fdone = 1'b0;
    logic rdy, rd_v, pstart, bstart, fstart, busy, fmode;
    logic [15:0] rd_d, p_a, p_d, tgt, bfirst;
    logic [5:0] bwords, bexp;
    logic [1:0] rstate;
    logic [7:0] status;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int n_buf = 0;
    int nw[2] = '{3, 32};
    always #4 clk = ~clk;
    flash_bus_if #(.AW(16)) bus ();
    flash_command_decoder #(.AW(16)) i_flash_command_decoder (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .BUS(bus.device), .I_SYNC_MODE(sync),
        .I_ARRAY_DATA(arr_d), .I_ID_DATA(id_d), .I_QUERY_DATA(qry_d), .I_FACTORY_DONE(fdone),
        .O_PROG_START(pstart), .O_BUF_PROG_START(bstart), .O_FACTORY_START(fstart),
        .O_PROG_ADDR(p_a), .O_PROG_DATA(p_d), .O_BUF_WORDS(bwords), .O_BUSY(busy),
        .O_FACTORY_MODE(fmode), .O_READ_STATE(rstate), .O_STATUS(status));
    flash_cmd_host #(.AW(16)) i_flash_cmd_host (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .BUS(bus.host), .I_REQ(req), .I_REQ_WRITE(req_wr),
        .I_REQ_ADDR(req_a), .I_REQ_DATA(req_d), .O_REQ_READY(rdy), .O_RD_VALID(rd_v),
        .O_RD_DATA(rd_d));
    flash_cmd_properties #(.AW(16)) i_props (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .ce_n(bus.ce_n), .we_n(bus.we_n), .addr(bus.addr),
        .dq_host(bus.dq_host), .O_PROG_START(pstart), .O_BUF_PROG_START(bstart),
        .O_FACTORY_START(fstart), .O_PROG_ADDR(p_a), .O_PROG_DATA(p_d), .O_BUSY(busy),
        .O_FACTORY_MODE(fmode), .O_READ_STATE(rstate), .O_STATUS(status));
    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        while (rdy !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) n_mismatch++;
        req <= 1'b1;
        req_wr <= w;
        req_a <= tgt;
        req_d <= d;
        @(posedge clk);
        req <= 1'b0;
        // lets the read state settle before the next access
        repeat (6) @(posedge clk);
    endtask : xfer
    task automatic wcmd(input logic [7:0] c);
        xfer(1'b1, {8'h00, c});
    endtask : wcmd
    task automatic rd(input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        xfer(1'b0, 16'h0000);
    endtask : rd
    task automatic idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) n_mismatch++;
    endtask : idle
    always @(posedge clk) begin : watch
        logic [15:0] m;
        if (rd_v === 1'b1 && msk_q.size() > 0) begin
            m = msk_q.pop_front();
            check(rd_d & m, exp_q.pop_front() & m);
        end
        if (bstart === 1'b1) begin
            n_buf++;
            check({10'h000, bwords}, {10'h000, bexp});
            check(p_d, bfirst);
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        void'($urandom(32'h19c9599c));
        tgt = 16'($urandom());
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        arr_d <= 16'($urandom());
        id_d <= 16'($urandom());
        qry_d <= 8'($urandom());
        @(posedge clk);
        rd(arr_d, 16'hFFFF);
        for (int s = 0; s < 2; s++) begin
            sync <= s[0];
            wcmd(`CMD_READ_ID);
            rd(id_d, 16'hFFFF);
            wcmd(`CMD_READ_QUERY);
            rd({8'h00, qry_d}, 16'h00FF);
            wcmd(`CMD_READ_STATUS);
            // first status read shows the older snapshot
            rd({8'h00, `STATUS_RESET}, 16'h00FF);
            rd({8'h00, `STATUS_RESET}, 16'h00FF);
            wcmd(`CMD_READ_ARRAY);
            rd(arr_d, 16'hFFFF);
        end
        for (int k = 0; k < 2; k++) begin
            tgt = 16'($urandom());
            wcmd(k ? `CMD_WORD_PROG_ALT : `CMD_WORD_PROG);
            xfer(1'b1, 16'($urandom()) & 16'hFF0F);
            wcmd(`CMD_READ_ARRAY);
            check({14'h0000, rstate}, 16'h0001);
            idle();
            wcmd(`CMD_READ_ARRAY);
            rd(arr_d, 16'hFFFF);
        end
        foreach (nw[i]) begin
            wcmd(`CMD_BUF_PROG);
            bexp = 6'(nw[i]);
            xfer(1'b1, 16'(nw[i] - 1));
            bfirst = 16'($urandom()) & 16'hFF0F;
            xfer(1'b1, bfirst);
            repeat (nw[i] - 1) xfer(1'b1, 16'($urandom()) & 16'hFF0F);
            wcmd(`CMD_CONFIRM);
            check({14'h0000, rstate}, 16'h0001);
            idle();
        end
        check(16'(n_buf), 16'h0002);
        wcmd(`CMD_FACTORY_SETUP);
        wcmd(8'h22);
        check({15'h0000, fmode}, 16'h0000);
        wcmd(`CMD_READ_STATUS);
        rd({8'h00, `STATUS_RESET | `STATUS_SEQ_ERR}, 16'h00FF);
        rd({8'h00, `STATUS_RESET | `STATUS_SEQ_ERR}, 16'h00FF);
        wcmd(`CMD_CLEAR_STATUS);
        rd({8'h00, `STATUS_RESET}, 16'h00FF);
        rd({8'h00, `STATUS_RESET}, 16'h00FF);
        wcmd(`CMD_FACTORY_SETUP);
        xfer(1'b1, {8'h00, `CMD_CONFIRM});
        check({15'h0000, fmode}, 16'h0001);
        wcmd(`CMD_READ_ID);
        wcmd(`CMD_READ_ARRAY);
        check({14'h0000, rstate}, 16'h0001);
        fdone <= 1'b1;
        @(posedge clk);
        fdone <= 1'b0;
        repeat (4) @(posedge clk);
        check({15'h0000, fmode}, 16'h0000);
        idle();
        wcmd(`CMD_WORD_PROG);
        xfer(1'b1, 16'($urandom()) & 16'hFF0F);
        // reset while programming must abandon the operation
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({8'h00, status}, {8'h00, `STATUS_RESET});
        rd(arr_d, 16'hFFFF);
        repeat (10) @(posedge clk);
        conclude();
    end
endmodule : tb
`default_nettype wire
